// >>> hw/fsag_pkg.sv
// package of constants for the flash security access guard
// assumes a 17-bit flash byte address space and the 64 KB device variant
package fsag_pkg;
	// ************************************************************
	// address layout
	// ************************************************************
	localparam int ADDR_W = 17;
	localparam int LOCK_W = 8;
	localparam int BLK_LSB = 14;
	localparam int BLK_N = 4;
	localparam int PAGE_LSB = 10;
	localparam int LIM_LSB = 9;
	localparam logic [ADDR_W-1:0] SEC_WE_ADDR = 17'h0fffe;
	localparam logic [ADDR_W-1:0] SEC_RD_ADDR = 17'h0ffff;
	localparam logic [ADDR_W-PAGE_LSB-1:0] SEC_PAGE = 7'h3f;
	localparam logic [ADDR_W-1:0] RSVD_BASE = 17'h10000;

	// ************************************************************
	// reset and erased values
	// ************************************************************
	localparam logic [LOCK_W-1:0] LIMIT_RST = 8'h00;
	localparam logic [LOCK_W-1:0] LOCK_ERASED = 8'hff;
	localparam logic [LOCK_W-1:0] LOCK_RST = 8'h00;

	// ************************************************************
	// register port map and status fields
	// ************************************************************
	localparam int REG_AW = 4;
	localparam logic [REG_AW-1:0] REG_LIMIT = 4'h0;
	localparam logic [REG_AW-1:0] REG_RDLOCK = 4'h4;
	localparam logic [REG_AW-1:0] REG_WELOCK = 4'h8;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'hc;
	localparam int ST_LIMIT_SET = 0;
	localparam int ST_LOADED = 1;
	localparam int ST_DENY_SEEN = 2;
	localparam int ST_ERASE_SEEN = 3;

	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		OP_FETCH = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b11,
		OP_ERASE = 2'b10
	} fsag_op_t;
	typedef enum logic [1:0] {
		LK_WAIT = 2'b00,
		LK_READY = 2'b01
	} fsag_lk_t;
	localparam logic SRC_FW = 1'b0;
	localparam logic SRC_DBG = 1'b1;
endpackage

// >>> hw/fsag_lock_sel.sv
// lock bit selector: picks the lock bit of the block an address falls in
// assumes block index taken from address bits above the 16 KB boundary
`timescale 1ns/100ps
module fsag_lock_sel
	import fsag_pkg::*;
#(
	parameter int NBLK = BLK_N
) (
	// block index and lock byte
	input logic [ADDR_W-BLK_LSB-1:0] i_blk,
	input logic [LOCK_W-1:0] i_lock,
	// block is open
	output logic o_open
);
	logic [LOCK_W-1:0] hit;

	// ************************************************************
	// per-bit block match
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < LOCK_W; g++) begin : g_bit
			// bits at or above nblk guard no block at all
			assign hit[g] = (g < NBLK) && (i_blk == (ADDR_W-BLK_LSB)'(g));
		end
	endgenerate

	// open only when the matching bit reads one
	assign o_open = |(hit & i_lock);
endmodule

// >>> hw/fsag_guard.sv
// flash security access guard: judges every flash access of firmware and debug
// assumes requests come from logic on i_sys_clk; the flash obeys o_resp_* only
`timescale 1ns/100ps
module fsag_guard
	import fsag_pkg::*;
#(
	parameter logic [ADDR_W-1:0] RSVD_LO = RSVD_BASE,
	parameter int NBLK = BLK_N
) (
	// clock, reset, enable
	input logic i_sys_clk,
	input logic i_rst_n,
	input logic i_clk_en,
	// register port
	input logic [REG_AW-1:0] i_reg_addr,
	input logic [LOCK_W-1:0] i_reg_wdata,
	input logic i_reg_wr,
	input logic i_reg_rd,
	output logic [LOCK_W-1:0] o_reg_rdata,
	// lock byte load from flash after power-up
	input logic i_lock_load,
	input logic [LOCK_W-1:0] i_lock_rd_byte,
	input logic [LOCK_W-1:0] i_lock_we_byte,
	// access request
	input logic i_req_valid,
	input logic i_req_src,
	input logic [1:0] i_req_op,
	input logic [ADDR_W-1:0] i_req_addr,
	input logic [ADDR_W-1:0] i_req_pc,
	input logic [LOCK_W-1:0] i_req_wdata,
	// verdict
	output logic o_resp_valid,
	output logic o_resp_grant,
	output logic o_resp_blank,
	output logic o_resp_page_reset,
	output logic o_resp_full_erase
);
	// ************************************************************
	// state
	// ************************************************************
	fsag_lk_t lk_state_r;
	fsag_lk_t lk_state_nxt;
	fsag_op_t op;
	logic [LOCK_W-1:0] limit_r;
	logic limit_set_r;
	logic [LOCK_W-1:0] rd_lock_r;
	logic [LOCK_W-1:0] we_lock_r;
	logic deny_seen_r;
	logic erase_seen_r;
	logic [LOCK_W-1:0] reg_rdata_r;
	logic resp_valid_r;
	logic resp_grant_r;
	logic resp_blank_r;
	logic resp_page_reset_r;
	logic resp_full_erase_r;

	// ************************************************************
	// decision signals
	// ************************************************************
	logic [ADDR_W-1:0] limit_addr;
	logic sec_byte;
	logic sec_page;
	logic rsvd;
	logic rd_open;
	logic we_open;
	logic fw_upper;
	logic fw_fenced;
	logic dbg_ok;
	logic dbg_page_clr;
	logic dbg_full;
	logic fw_ok;
	logic fw_blank;
	logic grant_nxt;
	logic blank_nxt;
	logic page_clr_nxt;
	logic full_nxt;
	logic sec_wr_go;
	logic lock_reset_go;
	logic limit_wr;
	logic status_wr;

	assign op = fsag_op_t'(i_req_op);

	// limit sits on 512-byte steps, low bits always zero
	assign limit_addr = {limit_r, {LIM_LSB{1'b0}}};

	// address classes
	assign sec_byte = (i_req_addr == SEC_WE_ADDR) || (i_req_addr == SEC_RD_ADDR);
	assign sec_page = (i_req_addr[ADDR_W-1:PAGE_LSB] == SEC_PAGE);
	assign rsvd = (i_req_addr >= RSVD_LO);

	// lock bits of the addressed block
	fsag_lock_sel #(
		.NBLK(NBLK)
	) u_rd_sel (
		.i_blk(i_req_addr[ADDR_W-1:BLK_LSB]),
		.i_lock(rd_lock_r),
		.o_open(rd_open)
	);
	fsag_lock_sel #(
		.NBLK(NBLK)
	) u_we_sel (
		.i_blk(i_req_addr[ADDR_W-1:BLK_LSB]),
		.i_lock(we_lock_r),
		.o_open(we_open)
	);

	// partition follows the executing instruction, not the target
	assign fw_upper = (i_req_pc >= limit_addr);
	assign fw_fenced = fw_upper && (i_req_addr < limit_addr);

	// ************************************************************
	// debug port verdict
	// ************************************************************
	// until the lock bytes are loaded every debug access is refused,
	// so a fresh reset never opens a window onto locked code
	always_comb begin
		dbg_ok = 1'b0;
		dbg_page_clr = 1'b0;
		dbg_full = 1'b0;
		if (lk_state_r != LK_READY) begin
			dbg_ok = 1'b0;
		end else if (rsvd) begin
			dbg_ok = 1'b0;
		end else begin
			case (op)
				OP_READ: begin
					dbg_ok = sec_byte || rd_open;
				end
				OP_WRITE: begin
					dbg_ok = sec_byte || we_open;
				end
				OP_ERASE: begin
					if (sec_page) begin
						// security page sits in the top block, so we_open is its bit
						if (we_open) begin
							dbg_ok = 1'b1;
							dbg_page_clr = 1'b1;
						end else if (sec_byte) begin
							dbg_ok = 1'b1;
							dbg_full = 1'b1;
						end else begin
							dbg_ok = 1'b0;
						end
					end else begin
						dbg_ok = we_open;
					end
				end
				default: begin
					// debug fetch is treated as a read of the block
					dbg_ok = rd_open;
				end
			endcase
		end
	end

	// ************************************************************
	// firmware verdict
	// ************************************************************
	// lock bytes are not consulted here at all
	always_comb begin
		fw_ok = 1'b0;
		fw_blank = 1'b0;
		if (rsvd) begin
			fw_ok = 1'b0;
			fw_blank = (op == OP_READ);
		end else begin
			case (op)
				OP_FETCH: begin
					fw_ok = 1'b1;
				end
				OP_READ: begin
					fw_ok = !fw_fenced;
					fw_blank = fw_fenced;
				end
				OP_WRITE: begin
					fw_ok = !fw_fenced;
				end
				default: begin
					fw_ok = !fw_fenced && !sec_page;
				end
			endcase
		end
	end

	// ************************************************************
	// merged verdict
	// ************************************************************
	always_comb begin
		grant_nxt = 1'b0;
		blank_nxt = 1'b0;
		page_clr_nxt = 1'b0;
		full_nxt = 1'b0;
		if (i_req_src == SRC_DBG) begin
			grant_nxt = dbg_ok;
			blank_nxt = !dbg_ok && (op == OP_READ);
			page_clr_nxt = dbg_page_clr;
			full_nxt = dbg_full;
		end else begin
			grant_nxt = fw_ok;
			blank_nxt = fw_blank;
		end
	end

	// granted write to a security byte from either path
	assign sec_wr_go = i_req_valid && grant_nxt && (op == OP_WRITE) && sec_byte;
	// erase of the security page or a full erase returns the locks to erased
	assign lock_reset_go = i_req_valid && (page_clr_nxt || full_nxt);
	assign limit_wr = i_reg_wr && (i_reg_addr == REG_LIMIT);
	assign status_wr = i_reg_wr && (i_reg_addr == REG_STATUS);

	// ************************************************************
	// lock load state
	// ************************************************************
	always_comb begin
		lk_state_nxt = lk_state_r;
		case (lk_state_r)
			LK_WAIT: begin
				if (i_lock_load) begin
					lk_state_nxt = LK_READY;
				end
			end
			default: begin
				lk_state_nxt = LK_READY;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk_state_r <= LK_WAIT;
		end else if (i_clk_en) begin
			lk_state_r <= lk_state_nxt;
		end
	end

	// ************************************************************
	// access limit register
	// ************************************************************
	// a second write cannot move the fence once firmware has set it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			limit_r <= LIMIT_RST;
			limit_set_r <= 1'b0;
		end else if (i_clk_en) begin
			if (limit_wr && !limit_set_r) begin
				limit_r <= i_reg_wdata;
				limit_set_r <= 1'b1;
			end
		end
	end

	// ************************************************************
	// lock byte shadows
	// ************************************************************
	// flash programming only clears bits, so writes are anded in;
	// this also means a write can lock more but never unlock
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_lock_r <= LOCK_RST;
			we_lock_r <= LOCK_RST;
		end else if (i_clk_en) begin
			if (lock_reset_go) begin
				rd_lock_r <= LOCK_ERASED;
				we_lock_r <= LOCK_ERASED;
			end else if (lk_state_r == LK_WAIT && i_lock_load) begin
				rd_lock_r <= i_lock_rd_byte;
				we_lock_r <= i_lock_we_byte;
			end else begin
				if (sec_wr_go && i_req_addr == SEC_RD_ADDR) begin
					rd_lock_r <= rd_lock_r & i_req_wdata;
				end else if (i_reg_wr && i_reg_addr == REG_RDLOCK) begin
					rd_lock_r <= rd_lock_r & i_reg_wdata;
				end
				if (sec_wr_go && i_req_addr == SEC_WE_ADDR) begin
					we_lock_r <= we_lock_r & i_req_wdata;
				end else if (i_reg_wr && i_reg_addr == REG_WELOCK) begin
					we_lock_r <= we_lock_r & i_reg_wdata;
				end
			end
		end
	end

	// ************************************************************
	// sticky status flags
	// ************************************************************
	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			deny_seen_r <= 1'b0;
			erase_seen_r <= 1'b0;
		end else if (i_clk_en) begin
			if (i_req_valid && !grant_nxt) begin
				deny_seen_r <= 1'b1;
			end else if (status_wr && i_reg_wdata[ST_DENY_SEEN]) begin
				deny_seen_r <= 1'b0;
			end
			if (lock_reset_go) begin
				erase_seen_r <= 1'b1;
			end else if (status_wr && i_reg_wdata[ST_ERASE_SEEN]) begin
				erase_seen_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// verdict registers
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			resp_valid_r <= 1'b0;
			resp_grant_r <= 1'b0;
			resp_blank_r <= 1'b0;
			resp_page_reset_r <= 1'b0;
			resp_full_erase_r <= 1'b0;
		end else if (i_clk_en) begin
			resp_valid_r <= i_req_valid;
			resp_grant_r <= i_req_valid && grant_nxt;
			resp_blank_r <= i_req_valid && blank_nxt;
			resp_page_reset_r <= i_req_valid && page_clr_nxt;
			resp_full_erase_r <= i_req_valid && full_nxt;
		end
	end

	// ************************************************************
	// register read port
	// ************************************************************
	// unmapped offsets read as zero; data stand only in the next cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reg_rdata_r <= 8'h00;
		end else if (i_clk_en) begin
			if (!i_reg_rd) begin
				reg_rdata_r <= 8'h00;
			end else if (i_reg_addr == REG_LIMIT) begin
				reg_rdata_r <= limit_r;
			end else if (i_reg_addr == REG_RDLOCK) begin
				reg_rdata_r <= rd_lock_r;
			end else if (i_reg_addr == REG_WELOCK) begin
				reg_rdata_r <= we_lock_r;
			end else if (i_reg_addr == REG_STATUS) begin
				reg_rdata_r <= 8'h00;
				reg_rdata_r[ST_LIMIT_SET] <= limit_set_r;
				reg_rdata_r[ST_LOADED] <= (lk_state_r == LK_READY);
				reg_rdata_r[ST_DENY_SEEN] <= deny_seen_r;
				reg_rdata_r[ST_ERASE_SEEN] <= erase_seen_r;
			end else begin
				reg_rdata_r <= 8'h00;
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_reg_rdata = reg_rdata_r;
	assign o_resp_valid = resp_valid_r;
	assign o_resp_grant = resp_grant_r;
	assign o_resp_blank = resp_blank_r;
	assign o_resp_page_reset = resp_page_reset_r;
	assign o_resp_full_erase = resp_full_erase_r;
endmodule

// >>> tb/fsag_guard_sva.sv
// assertion checker for the flash security access guard verdict and register ports
// assumes it is bound to fsag_guard and sees only that module's ports
`timescale 1ns/100ps
module fsag_guard_sva
	import fsag_pkg::*;
#(
	parameter logic [ADDR_W-1:0] RSVD_LO = RSVD_BASE,
	parameter int NBLK = BLK_N
) (
	// clock, reset, enable
	input logic i_sys_clk, i_rst_n, i_clk_en,
	// register port and lock load
	input logic [REG_AW-1:0] i_reg_addr,
	input logic [LOCK_W-1:0] i_reg_wdata, o_reg_rdata, i_lock_rd_byte, i_lock_we_byte,
	input logic i_reg_wr, i_reg_rd, i_lock_load,
	// request and verdict
	input logic i_req_valid, i_req_src,
	input logic [1:0] i_req_op,
	input logic [ADDR_W-1:0] i_req_addr, i_req_pc,
	input logic [LOCK_W-1:0] i_req_wdata,
	input logic o_resp_valid, o_resp_grant, o_resp_blank, o_resp_page_reset, o_resp_full_erase
);
	// ****
	// helper state
	// ****
	logic [LOCK_W-1:0] lim_r;
	logic set_r;
	logic ld_r;
	logic [ADDR_W-1:0] lim_a;
	logic fw_q;
	assign lim_a = {lim_r, {LIM_LSB{1'b0}}};
	assign fw_q = i_req_valid && i_req_src == SRC_FW;
	// shadow of the limit: only the first write after reset counts
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lim_r <= LIMIT_RST;
			set_r <= 1'b0;
			ld_r <= 1'b0;
		end else if (i_clk_en) begin
			if (i_reg_wr && i_reg_addr == REG_LIMIT && !set_r) begin
				lim_r <= i_reg_wdata;
				set_r <= 1'b1;
			end
			if (i_lock_load) begin
				ld_r <= 1'b1;
			end
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_resp_follows: assert property (i_req_valid && i_clk_en |=> o_resp_valid)
		else $error("request without verdict");
	a_idle_quiet: assert property (!o_resp_valid |->
		!(o_resp_grant || o_resp_blank || o_resp_page_reset || o_resp_full_erase))
		else $error("verdict bits without valid");
	a_rsvd_refused: assert property (i_req_valid && i_req_addr >= RSVD_LO |=> !o_resp_grant)
		else $error("reserved area granted");
	a_secbyte_read: assert property (i_req_valid && ld_r && i_req_src == SRC_DBG &&
		i_req_op == OP_READ && i_req_addr >= SEC_WE_ADDR && i_req_addr <= SEC_RD_ADDR |=> o_resp_grant)
		else $error("security byte read refused");
	a_fence_block: assert property (fw_q && i_req_op != OP_FETCH &&
		i_req_pc >= lim_a && i_req_addr < lim_a |=> !o_resp_grant)
		else $error("fenced access granted");
	a_fence_blank: assert property (fw_q && i_req_op == OP_READ &&
		i_req_pc >= lim_a && i_req_addr < lim_a |=> o_resp_blank)
		else $error("fenced read not blanked");
	a_lower_free: assert property (fw_q && i_req_op != OP_ERASE &&
		i_req_pc < lim_a && i_req_addr < RSVD_LO |=> o_resp_grant)
		else $error("lower partition access refused");
	a_fetch_free: assert property (fw_q && i_req_op == OP_FETCH && i_req_addr < RSVD_LO |=> o_resp_grant)
		else $error("fetch refused");
	a_fw_secerase: assert property (fw_q && i_req_op == OP_ERASE &&
		i_req_addr[ADDR_W-1:PAGE_LSB] == SEC_PAGE |=> !o_resp_grant)
		else $error("firmware erased security page");
	a_full_by_dbg: assert property (o_resp_full_erase |->
		$past(i_req_src) == SRC_DBG && $past(i_req_op) == OP_ERASE)
		else $error("full erase without debug erase");
	a_limit_read: assert property (i_reg_rd && i_reg_addr == REG_LIMIT |=> o_reg_rdata == lim_r)
		else $error("limit readback wrong");
	c_full_erase: cover property (o_resp_full_erase);
	c_page_reset: cover property (o_resp_page_reset);
	c_blank: cover property (o_resp_blank && i_req_src == SRC_FW);
endmodule

// >>> tb/fsag_flash_model.sv
// flash lock store: keeps both lock bytes through resets and replays them
// assumes the bench pulses i_go once after every guard reset
`timescale 1ns/100ps
module fsag_flash_model
	import fsag_pkg::*;
#(
	parameter logic [LOCK_W-1:0] RD_INIT = 8'h05,
	parameter logic [LOCK_W-1:0] WE_INIT = 8'h0b
) (
	// clock and commands
	input logic i_clk,
	input logic i_go,
	input logic i_page_reset,
	input logic i_full_erase,
	// lock byte load
	output logic o_load,
	output logic [LOCK_W-1:0] o_rd_byte,
	output logic [LOCK_W-1:0] o_we_byte
);
	// bytes of 0x0ffff and 0x0fffe; nonvolatile, so no reset
	logic [LOCK_W-1:0] rd_r = RD_INIT;
	logic [LOCK_W-1:0] we_r = WE_INIT;
	logic load_r = 1'b0;
	// either erase path leaves both bytes erased, all blocks open
	always @(posedge i_clk) begin
		load_r <= i_go;
		if (i_page_reset || i_full_erase) begin
			rd_r <= LOCK_ERASED;
			we_r <= LOCK_ERASED;
		end
	end
	// bytes are only held during the load pulse; otherwise show junk
	assign o_load = load_r;
	assign o_rd_byte = load_r ? rd_r : ~rd_r;
	assign o_we_byte = load_r ? we_r : ~we_r;
endmodule

// >>> tb/fsag_guard_test.sv
// self-checking bench for the flash security access guard
// assumes fsag_pkg, fsag_guard, the flash model and the checker compiled first
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module fsag_guard_test
	import fsag_pkg::*;
;
	localparam logic [7:0] RD0 = 8'h05;
	localparam logic [7:0] WE0 = 8'h0b;
	logic clk = 0, rst_n = 0, go = 0, reg_wr = 0, reg_rd = 0, valid = 0, src = 0, en = 1;
	logic load, rv, g, bl, pr, fe;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] wdata = 8'h00, rwd = 8'h00, rdata, rdb, web;
	logic [1:0] op = 2'h0;
	logic [16:0] addr = 17'h0, pc = 17'h0;
	int bad_count = 0, compares = 0;
	fsag_guard dut (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
		.i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.o_reg_rdata(rdata), .i_lock_load(load), .i_lock_rd_byte(rdb), .i_lock_we_byte(web),
		.i_req_valid(valid), .i_req_src(src), .i_req_op(op), .i_req_addr(addr),
		.i_req_pc(pc), .i_req_wdata(rwd), .o_resp_valid(rv), .o_resp_grant(g),
		.o_resp_blank(bl), .o_resp_page_reset(pr), .o_resp_full_erase(fe)
	);
	fsag_flash_model #(.RD_INIT(RD0), .WE_INIT(WE0)) flash (
		.i_clk(clk), .i_go(go), .i_page_reset(pr), .i_full_erase(fe),
		.o_load(load), .o_rd_byte(rdb), .o_we_byte(web)
	);
	// ****
	// bus tasks
	// ****
	task automatic wrap_up;
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// reset for two cycles, then let the flash replay the lock bytes
	task automatic t_rst;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	// e is {grant, page_reset, full_erase}; reads also judge blank
	task automatic rq(input logic s, input fsag_op_t o, input logic [16:0] a, p,
			input logic [7:0] d, input logic [2:0] e);
		@(posedge clk);
		valid <= 1'b1;
		src <= s;
		op <= o;
		addr <= a;
		pc <= p;
		rwd <= d;
		@(posedge clk);
		valid <= 1'b0;
		addr <= ~a;
		#1;
		`CHK({rv, g, pr, fe}, {1'b1, e})
		if (o == OP_READ) `CHK(bl, !e[2])
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs;
		rd(REG_LIMIT, 8'h00);
		wr(REG_LIMIT, 8'h40);
		wr(REG_LIMIT, 8'h20);
		rd(REG_LIMIT, 8'h40);
		rd(4'h2, 8'h00);
		wr(REG_RDLOCK, 8'hff);
		rd(REG_RDLOCK, RD0);
	endtask
	task automatic t_dbg;
		for (int b = 0; b < 4; b++) begin
			rq(SRC_DBG, OP_READ, {1'b0, 2'(b), 14'h0123}, 17'h0, 8'h00, {RD0[b], 2'b00});
			rq(SRC_DBG, OP_WRITE, {1'b0, 2'(b), 14'h0456}, 17'h0, 8'h00, {WE0[b], 2'b00});
		end
		rq(SRC_DBG, OP_ERASE, 17'h08400, 17'h0, 8'h00, 3'b000);
		rq(SRC_DBG, OP_ERASE, 17'h00400, 17'h0, 8'h00, 3'b100);
		rq(SRC_DBG, OP_READ, 17'h10010, 17'h0, 8'h00, 3'b000);
		rq(SRC_DBG, OP_READ, SEC_RD_ADDR, 17'h0, 8'h00, 3'b100);
		rq(SRC_DBG, OP_WRITE, SEC_WE_ADDR, 17'h0, 8'hff, 3'b100);
	endtask
	// limit 0x40 puts the partition edge at 0x08000
	task automatic t_fw;
		rq(SRC_FW, OP_READ, 17'h00100, 17'h09000, 8'h00, 3'b000);
		rq(SRC_FW, OP_READ, 17'h07fff, 17'h08000, 8'h00, 3'b000);
		rq(SRC_FW, OP_WRITE, 17'h08000, 17'h08000, 8'h00, 3'b100);
		rq(SRC_FW, OP_ERASE, 17'h04000, 17'h0a000, 8'h00, 3'b000);
		rq(SRC_FW, OP_READ, 17'h04000, 17'h07ffe, 8'h00, 3'b100);
		rq(SRC_FW, OP_FETCH, 17'h00100, 17'h09000, 8'h00, 3'b100);
		rq(SRC_FW, OP_ERASE, 17'h0fc00, 17'h00000, 8'h00, 3'b000);
		rq(SRC_FW, OP_WRITE, SEC_WE_ADDR, 17'h00000, 8'hff, 3'b100);
		rq(SRC_FW, OP_ERASE, SEC_RD_ADDR, 17'h00000, 8'h00, 3'b000);
	endtask
	task automatic t_erase;
		rq(SRC_DBG, OP_ERASE, 17'h0fc00, 17'h0, 8'h00, 3'b110);
		rd(REG_WELOCK, 8'hff);
		rq(SRC_DBG, OP_WRITE, SEC_WE_ADDR, 17'h0, 8'hf7, 3'b100);
		rq(SRC_DBG, OP_WRITE, SEC_RD_ADDR, 17'h0, 8'hfe, 3'b100);
		rd(REG_WELOCK, 8'hf7);
		rq(SRC_DBG, OP_ERASE, 17'h0fc00, 17'h0, 8'h00, 3'b000);
		rq(SRC_DBG, OP_ERASE, SEC_RD_ADDR, 17'h0, 8'h00, 3'b101);
		// limit set, locks loaded, a refusal and a lock erase all seen
		rd(REG_STATUS, 8'h0f);
		wr(REG_STATUS, 8'h0c);
		rd(REG_STATUS, 8'h03);
	endtask
	// second reset in mid-run re-arms the one-shot limit
	task automatic t_again;
		t_rst();
		rd(REG_LIMIT, 8'h00);
		rd(REG_RDLOCK, 8'hff);
		wr(REG_LIMIT, 8'h21);
		rd(REG_LIMIT, 8'h21);
		rq(SRC_FW, OP_READ, 17'h041ff, 17'h04200, 8'h00, 3'b000);
		rq(SRC_FW, OP_READ, 17'h04200, 17'h04200, 8'h00, 3'b100);
	endtask
	// enable is low on the edge after the one that takes a read; the read data must hold, not clear
	task automatic t_freeze;
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= REG_LIMIT;
		@(posedge clk);
		reg_rd <= 1'b0;
		en <= 1'b0;
		@(posedge clk);
		en <= 1'b1;
		#1;
		`CHK(rdata, 8'h21)
		@(posedge clk);
		#1;
		`CHK(rdata, 8'h00)
	endtask
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		t_rst();
		t_regs();
		t_dbg();
		t_fw();
		t_erase();
		t_again();
		t_freeze();
		wrap_up();
	end
	// hang guard
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
endmodule
bind fsag_guard fsag_guard_sva #(.RSVD_LO(RSVD_LO), .NBLK(NBLK)) u_sva (.*);
